// ### nonvolatile_sram_store_recall_tb.sv
// self-checking bench for the nonvolatile sram host controller
`default_nettype none
module nonvolatile_sram_store_recall_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic supply_low = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, ce_n, oe_n, we_n, data_bus_oe;
  logic store_busy_n_o, store_busy_n_oe, busy_pull;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [14:0] address_bus;
  logic [7:0] data_bus_o, dq_out;
  int save_cnt;
  int error_cnt = 0;
  int cmp_count = 0;
  // wired data bus and pulled-up shared busy pin
  wire logic [7:0] data_bus_i = data_bus_oe ? data_bus_o : dq_out;
  wire logic store_busy_n_i = !(store_busy_n_oe || busy_pull);

  initial begin
    forever #20 clk_sys = ~clk_sys;
  end

  nv_host #(.GRACE_CYC(4), .SAVE_CYC(20), .RESTORE_CYC(8)) dut (.clk_sys(clk_sys),
    .rst_b(rst_b), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .address_bus(address_bus), .data_bus_i(data_bus_i), .data_bus_o(data_bus_o),
    .data_bus_oe(data_bus_oe), .store_busy_n_i(store_busy_n_i),
    .store_busy_n_o(store_busy_n_o), .store_busy_n_oe(store_busy_n_oe));
  nvs_device_model dev (.clk_sys(clk_sys), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .address_bus(address_bus), .dq_in(data_bus_i), .busy_in(store_busy_n_i),
    .dq_out(dq_out), .busy_pull(busy_pull), .save_cnt(save_cnt), .supply_low(supply_low));

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // look at falling edges so the following rising edge is the taking one
  task automatic wait_for(input int sel);
    int n = 0;
    @(negedge clk_sys);
    while (!(sel == 0 ? awready : sel == 1 ? bvalid : sel == 2 ? arready : rvalid)) begin
      n++;
      if (n > 400) begin
        error_cnt++;
        wrap_up();
      end
      @(negedge clk_sys);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    wait_for(0);
    @(posedge clk_sys);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    wait_for(1);
    check("bresp", {30'h0, bresp}, {30'h0, er});
    @(posedge clk_sys);
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    wait_for(2);
    @(posedge clk_sys);
    arvalid <= 1'b0;
    wait_for(3);
    d = rdata;
    r = rresp;
    @(posedge clk_sys);
    rready <= 1'b0;
  endtask

  // start an operation, then poll status until done and not busy
  task automatic op(input logic [1:0] code, input logic hw);
    logic [31:0] st;
    logic [1:0] r;
    int n = 0;
    axi_wr(nv_host_pkg::CTRL_OFS, {28'h0, hw, code, 1'b1}, nv_host_pkg::RESP_OKAY);
    do begin
      axi_rd(nv_host_pkg::STATUS_OFS, st, r);
      n++;
      if (n > 500) begin
        error_cnt++;
        wrap_up();
      end
    end while (st[nv_host_pkg::STAT_DONE] !== 1'b1 || st[nv_host_pkg::STAT_BUSY] !== 1'b0);
  endtask

  task automatic sram_wr(input logic [14:0] a, input logic [7:0] d);
    axi_wr(nv_host_pkg::ADDR_OFS, {17'h0, a}, nv_host_pkg::RESP_OKAY);
    axi_wr(nv_host_pkg::WDATA_OFS, {24'h0, d}, nv_host_pkg::RESP_OKAY);
    op(nv_host_pkg::OP_WRITE, 1'b0);
  endtask

  task automatic sram_rd(input logic [14:0] a, output logic [31:0] d);
    logic [1:0] r;
    axi_wr(nv_host_pkg::ADDR_OFS, {17'h0, a}, nv_host_pkg::RESP_OKAY);
    op(nv_host_pkg::OP_READ, 1'b0);
    axi_rd(nv_host_pkg::RDATA_OFS, d, r);
  endtask

  // array corners and a middle address, written then read back
  task automatic t_rw();
    logic [31:0] d;
    sram_wr(15'h0000, 8'h3c);
    sram_wr(15'h7fff, 8'hc3);
    sram_wr(15'h4000, 8'h96);
    sram_rd(15'h0000, d);
    check("read low", d, 32'h3c);
    sram_rd(15'h7fff, d);
    check("read top", d, 32'hc3);
    sram_rd(15'h4000, d);
    check("read mid", d, 32'h96);
    $display("test rw done");
  endtask

  // software save, overwrite, software restore, then save with nothing written
  task automatic t_sw();
    logic [31:0] d;
    int s0 = save_cnt;
    sram_wr(15'h0123, 8'ha1);
    op(nv_host_pkg::OP_SAVE, 1'b0);
    check("sw save count", 32'(save_cnt), 32'(s0 + 1));
    sram_wr(15'h0123, 8'h11);
    op(nv_host_pkg::OP_RESTORE, 1'b0);
    sram_rd(15'h0123, d);
    check("sw restore data", d, 32'ha1);
    op(nv_host_pkg::OP_SAVE, 1'b0);
    check("sw save unwritten", 32'(save_cnt), 32'(s0 + 2));
    $display("test sw done");
  endtask

  // pin save after a write, then a pin save with nothing written
  task automatic t_pin();
    logic [31:0] d;
    int s0 = save_cnt;
    sram_wr(15'h0200, 8'h77);
    op(nv_host_pkg::OP_READ, 1'b1);
    check("pin save count", 32'(save_cnt), 32'(s0 + 1));
    op(nv_host_pkg::OP_READ, 1'b1);
    check("pin save skipped", 32'(save_cnt), 32'(s0 + 1));
    sram_wr(15'h0200, 8'h00);
    op(nv_host_pkg::OP_RESTORE, 1'b0);
    sram_rd(15'h0200, d);
    check("pin saved data", d, 32'h77);
    $display("test pin done");
  endtask

  // supply loss saves a written array; writes stay blocked while it lasts
  task automatic t_loss();
    logic [31:0] d;
    logic [1:0] r;
    int s0;
    sram_wr(15'h0300, 8'h5c);
    s0 = save_cnt;
    @(posedge clk_sys);
    supply_low <= 1'b1;
    axi_rd(nv_host_pkg::STATUS_OFS, d, r);
    check("pin low seen", d[nv_host_pkg::STAT_PIN_LOW], 1'b1);
    sram_wr(15'h0300, 8'ha3);
    check("loss save count", 32'(save_cnt), 32'(s0 + 1));
    sram_rd(15'h0300, d);
    check("loss write blocked", d, 32'h5c);
    @(posedge clk_sys);
    supply_low <= 1'b0;
    $display("test loss done");
  endtask

  // unmapped register addresses answer with an error
  task automatic t_err();
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(8'h20, d, r);
    check("bad read resp", {30'h0, r}, {30'h0, nv_host_pkg::RESP_SLVERR});
    check("bad read data", d, 32'h0);
    axi_wr(8'h24, 32'h5, nv_host_pkg::RESP_SLVERR);
    $display("test err done");
  endtask

  // main sequence after a five-cycle reset
  initial begin
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_rw();
    t_sw();
    t_pin();
    t_loss();
    t_err();
    wrap_up();
  end
endmodule
`default_nettype wire

// ### nv_host.sv
// host controller for a nonvolatile sram, driven by software over axi4-lite
// Summary of operation
// - host holds address, keeps oe high writing
// - sequence starts with three fixed reads
// - two more reads, sixth address saves
// - alternative sixth address restores instead
//
// The register offsets and the AXI4-Lite interface to the registers were chosen for this implementation.
`default_nettype none
module nv_host #(
  parameter int unsigned GRACE_CYC = nv_host_pkg::GRACE_CYC,
  parameter int unsigned SAVE_CYC = nv_host_pkg::SAVE_CYC,
  parameter int unsigned RESTORE_CYC = nv_host_pkg::RESTORE_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  output logic [14:0] address_bus,
  input wire logic [7:0] data_bus_i,
  output logic [7:0] data_bus_o,
  output logic data_bus_oe,
  input wire logic store_busy_n_i,
  output logic store_busy_n_o,
  output logic store_busy_n_oe
);
  typedef struct packed {
    nv_host_pkg::state_t st;
    logic [nv_host_pkg::CNT_W-1:0] cnt;
    logic [14:0] addr;
    logic [7:0] wdat;
    logic [7:0] rdat;
    logic [1:0] op;
    logic [2:0] seq;
    logic done;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic dq_oe;
    logic hs_oe;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } regs_t;

  regs_t r_q;
  regs_t r_d;
  logic wr_take;
  logic rd_take;
  logic idle;
  logic sw_op;

  // address of step i of the software sequence
  function automatic logic [14:0] seq_addr(input logic [2:0] i, input logic [1:0] op);
    case (i)
      3'h0: seq_addr = nv_host_pkg::SEQ_A0;
      3'h1: seq_addr = nv_host_pkg::SEQ_A1;
      3'h2: seq_addr = nv_host_pkg::SEQ_A2;
      3'h3: seq_addr = nv_host_pkg::SEQ_A3;
      3'h4: seq_addr = nv_host_pkg::SEQ_A4;
      default: seq_addr = (op == nv_host_pkg::OP_RESTORE) ? nv_host_pkg::RESTORE_ADDR
                                                         : nv_host_pkg::SAVE_ADDR;
    endcase
  endfunction

  // both write channels are taken together; one response outstanding at most
  assign wr_take = awvalid && wvalid && !r_q.bvalid;
  assign awready = wr_take;
  assign wready = wr_take;
  assign arready = !r_q.rvalid;
  assign rd_take = arvalid && !r_q.rvalid;
  assign idle = (r_q.st == nv_host_pkg::S_IDLE);
  assign sw_op = r_q.op[1];

  // next state: bus slave first, then the pin sequencer so its set wins
  always_comb begin
    r_d = r_q;
    if (r_q.bvalid && bready) begin
      r_d.bvalid = 1'b0;
    end
    if (r_q.rvalid && rready) begin
      r_d.rvalid = 1'b0;
    end
    if (wr_take) begin
      r_d.bvalid = 1'b1;
      r_d.bresp = nv_host_pkg::RESP_OKAY;
      case (awaddr)
        nv_host_pkg::CTRL_OFS: begin
          if (!idle) begin
            r_d.bresp = nv_host_pkg::RESP_SLVERR;
          end else if (wstrb[0] && wdata[nv_host_pkg::CTRL_GO]) begin
            r_d.done = 1'b0;
            r_d.seq = 3'h0;
            if (wdata[nv_host_pkg::CTRL_HW]) begin
              // hold the shared busy pin low for the grace time
              r_d.st = nv_host_pkg::S_HSREQ;
              r_d.hs_oe = 1'b1;
              r_d.cnt = nv_host_pkg::CNT_W'(GRACE_CYC - 1);
            end else begin
              r_d.op = wdata[nv_host_pkg::CTRL_OP_LO +: 2];
              r_d.st = nv_host_pkg::S_SETUP;
              r_d.dq_oe = (wdata[nv_host_pkg::CTRL_OP_LO +: 2] == nv_host_pkg::OP_WRITE);
              if (wdata[nv_host_pkg::CTRL_OP_LO + 1]) begin
                r_d.addr = nv_host_pkg::SEQ_A0;
              end
            end
          end
        end
        nv_host_pkg::ADDR_OFS: begin
          if (!idle) begin
            r_d.bresp = nv_host_pkg::RESP_SLVERR; // address frozen mid access
          end else begin
            if (wstrb[0]) begin
              r_d.addr[7:0] = wdata[7:0];
            end
            if (wstrb[1]) begin
              r_d.addr[14:8] = wdata[14:8];
            end
          end
        end
        nv_host_pkg::WDATA_OFS: begin
          if (wstrb[0] && idle) begin
            r_d.wdat = wdata[7:0];
          end
        end
        default: r_d.bresp = nv_host_pkg::RESP_SLVERR;
      endcase
    end
    if (rd_take) begin
      r_d.rvalid = 1'b1;
      r_d.rresp = nv_host_pkg::RESP_OKAY;
      r_d.rdata = 32'h0000_0000;
      case (araddr)
        nv_host_pkg::CTRL_OFS: r_d.rdata[nv_host_pkg::CTRL_OP_LO +: 2] = r_q.op;
        nv_host_pkg::ADDR_OFS: r_d.rdata[14:0] = r_q.addr;
        nv_host_pkg::WDATA_OFS: r_d.rdata[7:0] = r_q.wdat;
        nv_host_pkg::RDATA_OFS: r_d.rdata[7:0] = r_q.rdat;
        nv_host_pkg::STATUS_OFS: begin
          r_d.rdata[nv_host_pkg::STAT_BUSY] = !idle;
          r_d.rdata[nv_host_pkg::STAT_DONE] = r_q.done;
          r_d.rdata[nv_host_pkg::STAT_PIN_LOW] = !store_busy_n_i;
          r_d.rdata[nv_host_pkg::STAT_SEQ_LO +: 3] = r_q.seq;
        end
        default: r_d.rresp = nv_host_pkg::RESP_SLVERR;
      endcase
    end
    case (r_q.st)
      nv_host_pkg::S_IDLE: begin
        r_d.dq_oe = r_d.dq_oe;
      end
      nv_host_pkg::S_SETUP: begin
        // no access starts while the busy pin is low
        if (store_busy_n_i) begin
          r_d.st = nv_host_pkg::S_ACC;
          r_d.ce_n = 1'b0;
          r_d.oe_n = (r_q.op == nv_host_pkg::OP_WRITE);
          r_d.we_n = (r_q.op != nv_host_pkg::OP_WRITE);
          r_d.cnt = nv_host_pkg::CNT_W'(nv_host_pkg::ACC_CYC - 1);
        end
      end
      nv_host_pkg::S_ACC: begin
        if (r_q.cnt != '0) begin
          r_d.cnt = r_q.cnt - 1'b1;
        end else begin
          // ce rises so each sequence read is ce controlled
          r_d.ce_n = 1'b1;
          r_d.oe_n = 1'b1;
          r_d.we_n = 1'b1;
          if (r_q.op != nv_host_pkg::OP_WRITE) begin
            r_d.rdat = data_bus_i;
          end
          r_d.st = nv_host_pkg::S_GAP;
        end
      end
      nv_host_pkg::S_GAP: begin
        // address and data held one cycle past the rising strobe
        r_d.dq_oe = 1'b0;
        if (sw_op && r_q.seq != nv_host_pkg::SEQ_LAST) begin
          r_d.seq = r_q.seq + 3'h1;
          r_d.addr = seq_addr(r_q.seq + 3'h1, r_q.op);
          r_d.st = nv_host_pkg::S_SETUP;
        end else if (sw_op) begin
          r_d.seq = 3'h0;
          r_d.st = nv_host_pkg::S_NVWAIT;
          r_d.cnt = (r_q.op == nv_host_pkg::OP_SAVE) ? nv_host_pkg::CNT_W'(SAVE_CYC - 1)
                                                     : nv_host_pkg::CNT_W'(RESTORE_CYC - 1);
        end else begin
          r_d.done = 1'b1;
          r_d.st = nv_host_pkg::S_IDLE;
        end
      end
      nv_host_pkg::S_NVWAIT: begin
        // the chip is disabled for the whole save or restore time
        if (r_q.cnt != '0) begin
          r_d.cnt = r_q.cnt - 1'b1;
        end else begin
          r_d.st = nv_host_pkg::S_BUSYWAIT;
        end
      end
      nv_host_pkg::S_HSREQ: begin
        if (r_q.cnt != '0) begin
          r_d.cnt = r_q.cnt - 1'b1;
        end else begin
          r_d.hs_oe = 1'b0;
          r_d.st = nv_host_pkg::S_BUSYWAIT;
        end
      end
      nv_host_pkg::S_BUSYWAIT: begin
        // device holds the pin low while saving; wait for release
        if (store_busy_n_i) begin
          r_d.done = 1'b1;
          r_d.st = nv_host_pkg::S_IDLE;
        end
      end
      default: r_d.st = nv_host_pkg::S_IDLE;
    endcase
  end

  // single state register
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      r_q <= '{st: nv_host_pkg::S_IDLE, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
               op: nv_host_pkg::OP_READ, default: '0};
    end else begin
      r_q <= r_d;
    end
  end

  // pin outputs and bus responses straight from flip-flops, except the busy pin drive value, which is tied low
  assign bvalid = r_q.bvalid;
  assign bresp = r_q.bresp;
  assign rvalid = r_q.rvalid;
  assign rdata = r_q.rdata;
  assign rresp = r_q.rresp;
  assign ce_n = r_q.ce_n;
  assign oe_n = r_q.oe_n;
  assign we_n = r_q.we_n;
  assign address_bus = r_q.addr;
  assign data_bus_o = r_q.wdat;
  assign data_bus_oe = r_q.dq_oe;
  assign store_busy_n_o = 1'b0; // open drain: only ever pulls low
  assign store_busy_n_oe = r_q.hs_oe;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  sequence sw_read_s;
    $fell(ce_n) && sw_op;
  endsequence
  sequence sixth_read_s;
    $fell(ce_n) && sw_op && r_q.seq == 3'h5;
  endsequence

  read_strobes_a: assert property ($fell(ce_n) && r_q.op == nv_host_pkg::OP_READ
    |-> !oe_n && we_n ##1 !ce_n ##1 ce_n && oe_n)
    else $error("read strobes wrong shape");
  write_oe_high_a: assert property (!we_n |-> oe_n && data_bus_oe)
    else $error("oe low or data off during write");
  write_addr_hold_a: assert property (!we_n |=> $stable(address_bus))
    else $error("address moved during write");
  busy_blocks_a: assert property ($fell(ce_n) |-> $past(store_busy_n_i))
    else $error("access started while busy pin low");
  seq_first_a: assert property (sw_read_s and (r_q.seq == 3'h0)
    |-> address_bus == nv_host_pkg::SEQ_A0)
    else $error("sequence does not open with first address");
  seq_sixth_a: assert property (sixth_read_s |-> address_bus ==
    ((r_q.op == nv_host_pkg::OP_RESTORE) ? nv_host_pkg::RESTORE_ADDR : nv_host_pkg::SAVE_ADDR))
    else $error("sixth address wrong for operation");
  seq_step_a: assert property (sw_read_s and (r_q.seq < 3'h5)
    |-> ##[3:600] $fell(ce_n) && r_q.seq == $past(r_q.seq, 3) + 3'h1)
    else $error("sequence step not advanced");
  nv_quiet_a: assert property (sixth_read_s |-> ##3 r_q.st == nv_host_pkg::S_NVWAIT
    && r_q.seq == 3'h0 ##1 ce_n[*4])
    else $error("chip accessed after sequence start");
  grace_pull_a: assert property ($fell(store_busy_n_oe) |-> $past(r_q.cnt) == '0
    && r_q.st == nv_host_pkg::S_BUSYWAIT)
    else $error("busy pin released early");
  resp_after_take_a: assert property (wr_take |=> bvalid)
    else $error("write not answered");
endmodule
`default_nettype wire

// ### nv_host_pkg.sv
// constants, types and register map for the nonvolatile sram host controller
`default_nettype none
package nv_host_pkg;
  // clock and pin timing
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned ADDRESS_ACCESS_TIME_NS = 45;
  localparam int unsigned ACC_CYC = (ADDRESS_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // nonvolatile timing; plain defaults, the real figures are set per board
  localparam int unsigned STORE_GRACE_TIME_NS = 25000;
  localparam int unsigned NV_SAVE_TIME_NS = 12500000;
  localparam int unsigned NV_RESTORE_TIME_NS = 20000;
  localparam int unsigned GRACE_CYC = (STORE_GRACE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SAVE_CYC = (NV_SAVE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RESTORE_CYC = (NV_RESTORE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 20;
  // software sequence addresses
  localparam logic [14:0] SEQ_A0 = 15'h0e38;
  localparam logic [14:0] SEQ_A1 = 15'h31c7;
  localparam logic [14:0] SEQ_A2 = 15'h03e0;
  localparam logic [14:0] SEQ_A3 = 15'h3c1f;
  localparam logic [14:0] SEQ_A4 = 15'h303f;
  localparam logic [14:0] SAVE_ADDR = 15'h0fc0;
  localparam logic [14:0] RESTORE_ADDR = 15'h0c63;
  localparam logic [2:0] SEQ_LAST = 3'h5;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] ADDR_OFS = 8'h04;
  localparam logic [7:0] WDATA_OFS = 8'h08;
  localparam logic [7:0] RDATA_OFS = 8'h0c;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  // field positions
  localparam int unsigned CTRL_GO = 0;
  localparam int unsigned CTRL_OP_LO = 1;
  localparam int unsigned CTRL_HW = 3;
  localparam int unsigned STAT_BUSY = 0;
  localparam int unsigned STAT_DONE = 1;
  localparam int unsigned STAT_PIN_LOW = 2;
  localparam int unsigned STAT_SEQ_LO = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // operation codes
  localparam logic [1:0] OP_READ = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_SAVE = 2'h2;
  localparam logic [1:0] OP_RESTORE = 2'h3;
  typedef enum logic [6:0] {
    S_IDLE = 7'h01, S_SETUP = 7'h02, S_ACC = 7'h04, S_GAP = 7'h08,
    S_HSREQ = 7'h10, S_NVWAIT = 7'h20, S_BUSYWAIT = 7'h40
  } state_t;
endpackage
`default_nettype wire

// ### nvs_device_model.sv
// behavioural model of the nonvolatile sram device on the far side of the host
`default_nettype none
module nvs_device_model #(
  parameter int SAVE_T = 16,
  parameter int REST_T = 6,
  parameter int GRACE_T = 2,
  parameter bit LOSS_SAVE_OFF = 1'b0
) (
  input wire logic clk_sys,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [14:0] address_bus,
  input wire logic [7:0] dq_in,
  input wire logic busy_in,
  input wire logic supply_low,
  output logic [7:0] dq_out,
  output logic busy_pull = 1'b0,
  output int save_cnt = 0
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [14:0] SEQ [0:4] = '{nv_host_pkg::SEQ_A0, nv_host_pkg::SEQ_A1,
    nv_host_pkg::SEQ_A2, nv_host_pkg::SEQ_A3, nv_host_pkg::SEQ_A4};
  logic [7:0] mem [0:32767];
  logic [7:0] nv [0:32767];
  logic [7:0] flt = 8'h5a;
  logic written = 1'b0;
  // power-up restore keeps the chip off for its first cycles
  logic off = 1'b1;
  logic ce_q = 1'b1;
  logic supply_q = 1'b0;
  int step = 0;
  int busy_t = REST_T;
  int grace_t = 0;
  // a released bus toggles every cycle so a stale byte never passes as a read
  // we low turns the outputs off, so a write never fights the host
  assign dq_out = (!ce_n && !oe_n && we_n && busy_in && !off)
    ? mem[address_bus] : flt;
  // save copies the whole array and pulls the shared pin low while it runs
  task automatic start_save();
    foreach (nv[i]) nv[i] <= mem[i];
    written <= 1'b0;
    off <= 1'b1;
    busy_pull <= 1'b1;
    busy_t <= SAVE_T;
    save_cnt <= save_cnt + 1;
  endtask
  // all device behaviour, timed on the host clock for simplicity
  always @(posedge clk_sys) begin
    flt <= ~flt;
    ce_q <= ce_n;
    if (busy_t != 0) begin
      // a pin held high from outside means the save attempt is abandoned
      busy_t <= (busy_pull && busy_in && busy_t == SAVE_T) ? 1 : busy_t - 1;
      if (busy_t == 1) busy_pull <= 1'b0;
    end else if (off && busy_in) begin
      off <= 1'b0;
    end
    if (!ce_n && !we_n && busy_in && !off && !supply_low) begin
      mem[address_bus] <= dq_in;
      written <= 1'b1;
    end
    if (ce_q && !ce_n && !off) begin
      if (!we_n) step <= 0;
      else if (step < 5) step <= (address_bus == SEQ[step]) ? step + 1 : 0;
      else begin
        step <= 0;
        if (address_bus == nv_host_pkg::SAVE_ADDR) start_save();
        else if (address_bus == nv_host_pkg::RESTORE_ADDR) begin
          foreach (mem[i]) mem[i] <= nv[i];
          written <= 1'b0;
          off <= 1'b1;
          busy_t <= REST_T;
        end
      end
    end
    // supply loss saves on the capacitor unless strapped off; written array only
    supply_q <= supply_low;
    if (supply_low && !supply_q && written && busy_t == 0) begin
      if (!LOSS_SAVE_OFF) start_save();
    end
    // outside pull on the shared pin asks for a save after the grace time
    if (!busy_in && !busy_pull) begin
      grace_t <= grace_t + 1;
      if (grace_t == GRACE_T && written) start_save();
    end else grace_t <= 0;
  end
endmodule
`default_nettype wire
